/* isat_defs.vh */
// Constants for the two-wire slave address and transfer block
// Notes on behaviour
// - Matched address or data: auto acknowledge, load buffer.
// - No acknowledge if buffer-full or overflow already set.
// - Buffer-full at completion: no load, set irq, overflow.
// - Overflow only: load buffer, set irq, no acknowledge.
// - Buffer read clears full; overflow cleared by software.
// - After enable, wait start, sample eight bits rising.
// - Compare shift bits 7:1 with own address.
// - Load/full at 8th fall; irq at 9th fall.
// - 10-bit high byte is 11110 A9 A8 write.
// - Each 10-bit half: flags, hold clock; address write releases.
// - After repeated start, high byte alone matches for read.
// - Write-direction match clears direction bit, buffers address.
// - Read-direction match sets direction, acknowledges, holds clock.
// - Transmit write loads shifter; release bit frees clock.
// - Transmit MSB first, data changes on clock fall.
// - Irq flag set at ninth fall; software clears it.
// - Master ack at ninth rise: high resets, low continues.
// - General call enabled: all-zero write address matches.
// - 10-bit general call skips second half and refresh flag.
// - In sleep still receive; wake on irq if enabled.
// - Any reset disables module, abandons transfer.
// - Active only with port enable; enable takes pins.
// - Low four control bits select slave addressing mode.
`ifndef ISAT_DEFS_VH
`define ISAT_DEFS_VH
`define ISAT_MODE_SLAVE7 4'h6
`define ISAT_MODE_SLAVE10 4'h7
`define ISAT_TEN_BIT_PREFIX 5'h1E
`define ISAT_GCALL_ADDR 8'h00
`define ISAT_BITS_PER_BYTE 4'h8
`define ISAT_ACK_SLOT 4'h9
`define ISAT_STAGE_DATA 2'h0
`define ISAT_STAGE_FIRST 2'h1
`define ISAT_STAGE_SECOND 2'h2
`define ISAT_OWN_ADDR_RESET 8'h00
`endif

/* isat_rx_fifo.v */
// Two-entry receive buffer with valid/ready on both sides
`timescale 1ns/1ps
module isat_rx_fifo #(
   parameter WIDTH = 8
) (
   input wire clk_sys,
   input wire rst,
   input wire in_valid,
   output reg in_ready,
   input wire [WIDTH-1:0] in_data,
   output reg out_valid,
   input wire out_ready,
   output reg [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] spare_reg;
   reg spare_valid_reg;
   wire push;
   wire pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Head register feeds the output, spare slot backs it up
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         out_valid <= 1'b0;
         out_data <= {WIDTH{1'b0}};
         spare_reg <= {WIDTH{1'b0}};
         spare_valid_reg <= 1'b0;
         in_ready <= 1'b1;
      end
      else
      begin
         if (pop)
         begin
            if (spare_valid_reg)
            begin
               out_data <= spare_reg;
               out_valid <= 1'b1;
               spare_valid_reg <= push;
               spare_reg <= in_data;
            end
            else
            begin
               out_valid <= push;
               out_data <= in_data;
            end
         end
         else if (push)
         begin
            if (!out_valid)
            begin
               out_valid <= 1'b1;
               out_data <= in_data;
            end
            else
            begin
               spare_valid_reg <= 1'b1;
               spare_reg <= in_data;
            end
         end
         // Full when both slots are taken after this edge
         in_ready <= ~((out_valid | push) & (spare_valid_reg | (push & out_valid & ~pop)))
                     | (pop & ~(spare_valid_reg & push));
      end
   end
endmodule

/* isat_slave.v */
// Two-wire slave: address match, receive, transmit and clock stretching
`timescale 1ns/1ps
`include "isat_defs.vh"
module isat_slave #(
   parameter DATA_W = 8
) (
   input wire clk_sys,
   input wire rst,
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   input wire port_enable_bit,
   input wire [3:0] mode_sel,
   input wire general_call_enable,
   input wire own_address_wr,
   input wire [DATA_W-1:0] own_address_data,
   input wire buffer_rd,
   output wire [DATA_W-1:0] serial_data_buffer,
   output wire buffer_full_flag,
   input wire tx_wr,
   input wire [DATA_W-1:0] tx_data,
   input wire clock_release_set,
   output reg clock_release_bit,
   output reg receive_overflow_flag,
   input wire overflow_clear,
   output reg serial_irq_flag,
   input wire irq_flag_clear,
   input wire irq_enable,
   input wire sleep_mode,
   output reg wake_req,
   output reg address_refresh_flag,
   output reg direction_flag
);
   localparam ST_IDLE = 3'h0;
   localparam ST_RX = 3'h1;
   localparam ST_ACK = 3'h2;
   localparam ST_TX = 3'h3;
   localparam ST_TXACK = 3'h4;

   reg scl_s1_reg, scl_s2_reg, scl_prev_reg;
   reg sda_s1_reg, sda_s2_reg, sda_prev_reg;
   reg [2:0] state_reg;
   reg [3:0] cnt_reg;
   reg [DATA_W-1:0] shift_reg;
   reg [1:0] stage_reg;
   reg [DATA_W-1:0] own_address_register;
   reg tenbit_ok_reg;
   reg ua_pend_reg;
   reg tx_pend_reg;
   reg ua_hold_reg;
   reg tx_hold_reg;
   reg nack_reg;
   reg push_reg;
   reg [DATA_W-1:0] push_data_reg;
   wire fifo_in_ready;
   wire scl_rise, scl_fall, start_det, stop_det;
   wire active, ten_mode;
   wire rw, gc_hit, hi_hit, m7, m10, lo_hit, accept;
   wire byte_done, irq_set, ovf_set, ua_event;

   // Seven upper address bits compared against own address
   function addr7_match;
      input [DATA_W-1:0] a;
      input [DATA_W-1:0] b;
      begin
         addr7_match = (a[7:1] == b[7:1]);
      end
   endfunction

   // Two-flop synchronisers plus history for edge finding
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end
      else
      begin
         scl_s1_reg <= scl_in;
         scl_s2_reg <= scl_s1_reg;
         scl_prev_reg <= scl_s2_reg;
         sda_s1_reg <= sda_in;
         sda_s2_reg <= sda_s1_reg;
         sda_prev_reg <= sda_s2_reg;
      end
   end

   // Bus events
   assign scl_rise = scl_s2_reg & ~scl_prev_reg;
   assign scl_fall = ~scl_s2_reg & scl_prev_reg;
   assign start_det = scl_s2_reg & scl_prev_reg & sda_prev_reg & ~sda_s2_reg;
   assign stop_det = scl_s2_reg & scl_prev_reg & ~sda_prev_reg & sda_s2_reg;

   // Mode select and enable
   assign ten_mode = (mode_sel == `ISAT_MODE_SLAVE10);
   assign active = port_enable_bit & (ten_mode | (mode_sel == `ISAT_MODE_SLAVE7));

   // Address decode on the completed byte
   assign rw = shift_reg[0];
   assign gc_hit = general_call_enable & (shift_reg == `ISAT_GCALL_ADDR);
   assign hi_hit = addr7_match(shift_reg, own_address_register);
   assign m7 = ~ten_mode & hi_hit;
   assign m10 = ten_mode & (shift_reg[7:3] == `ISAT_TEN_BIT_PREFIX) & hi_hit
                & (~rw | tenbit_ok_reg);
   assign lo_hit = (shift_reg == own_address_register);
   assign byte_done = (state_reg == ST_RX) & scl_fall & (cnt_reg == `ISAT_BITS_PER_BYTE);
   assign accept = (stage_reg == `ISAT_STAGE_DATA) | gc_hit | m7
                   | ((stage_reg == `ISAT_STAGE_FIRST) & m10)
                   | ((stage_reg == `ISAT_STAGE_SECOND) & lo_hit);
   assign ovf_set = byte_done & accept & buffer_full_flag;
   // Low address half carries no direction bit, so it always refreshes
   assign ua_event = byte_done & accept & ten_mode & ~gc_hit & ((stage_reg == `ISAT_STAGE_SECOND)
                     | ((stage_reg == `ISAT_STAGE_FIRST) & ~rw));
   assign irq_set = scl_fall & (cnt_reg == `ISAT_ACK_SLOT)
                    & ((state_reg == ST_ACK) | (state_reg == ST_TXACK));

   // Receive buffer between shifter and software
   isat_rx_fifo #(
      .WIDTH(DATA_W)
   ) u_rx_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(push_reg),
      .in_ready(fifo_in_ready),
      .in_data(push_data_reg),
      .out_valid(buffer_full_flag),
      .out_ready(buffer_rd),
      .out_data(serial_data_buffer)
   );

   // Own address register, written by software
   always @(posedge clk_sys)
   begin
      if (rst)
         own_address_register <= `ISAT_OWN_ADDR_RESET;
      else if (own_address_wr)
         own_address_register <= own_address_data;
   end

   // Software-cleared flags; hardware set wins over clear
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         receive_overflow_flag <= 1'b0;
         serial_irq_flag <= 1'b0;
         address_refresh_flag <= 1'b0;
         wake_req <= 1'b0;
      end
      else
      begin
         if (ovf_set)
            receive_overflow_flag <= 1'b1;
         else if (overflow_clear)
            receive_overflow_flag <= 1'b0;
         if (irq_set)
            serial_irq_flag <= 1'b1;
         else if (irq_flag_clear)
            serial_irq_flag <= 1'b0;
         if (ua_event)
            address_refresh_flag <= 1'b1;
         else if (own_address_wr)
            address_refresh_flag <= 1'b0;
         wake_req <= sleep_mode & irq_enable & (irq_set | (wake_req & serial_irq_flag));
      end
   end

   // Main transfer sequencer
   always @(posedge clk_sys)
   begin
      if (rst | ~active)
      begin
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         shift_reg <= {DATA_W{1'b0}};
         stage_reg <= `ISAT_STAGE_DATA;
         tenbit_ok_reg <= 1'b0;
         ua_pend_reg <= 1'b0;
         tx_pend_reg <= 1'b0;
         ua_hold_reg <= 1'b0;
         tx_hold_reg <= 1'b0;
         nack_reg <= 1'b0;
         push_reg <= 1'b0;
         push_data_reg <= {DATA_W{1'b0}};
         direction_flag <= 1'b0;
         clock_release_bit <= 1'b0;
         sda_oe <= 1'b0;
      end
      else
      begin
         push_reg <= 1'b0;
         if (clock_release_set)
         begin
            clock_release_bit <= 1'b1;
            tx_hold_reg <= 1'b0;
         end
         if (own_address_wr)
            ua_hold_reg <= 1'b0;
         if (tx_wr & (state_reg == ST_TX) & (cnt_reg == 4'h0))
            shift_reg <= tx_data;
         if (start_det)
         begin
            state_reg <= ST_RX;
            cnt_reg <= 4'h0;
            stage_reg <= `ISAT_STAGE_FIRST;
            sda_oe <= 1'b0;
            tx_hold_reg <= 1'b0;
            ua_hold_reg <= 1'b0;
         end
         else if (stop_det)
         begin
            state_reg <= ST_IDLE;
            tenbit_ok_reg <= 1'b0;
            sda_oe <= 1'b0;
         end
         else
         begin
            case (state_reg)
               ST_IDLE: sda_oe <= 1'b0;
               ST_RX:
               begin
                  if (scl_rise & (cnt_reg < `ISAT_BITS_PER_BYTE))
                  begin
                     shift_reg <= {shift_reg[DATA_W-2:0], sda_s2_reg};
                     cnt_reg <= cnt_reg + 4'h1;
                  end
                  else if (byte_done)
                  begin
                     if (accept)
                     begin
                        // Load only with buffer free; ack only with both flags clear
                        push_reg <= ~buffer_full_flag;
                        push_data_reg <= shift_reg;
                        sda_oe <= ~buffer_full_flag & ~receive_overflow_flag;
                        state_reg <= ST_ACK;
                        ua_pend_reg <= ua_event;
                        tx_pend_reg <= (stage_reg == `ISAT_STAGE_FIRST) & ~gc_hit & rw;
                        if (stage_reg == `ISAT_STAGE_FIRST)
                           direction_flag <= rw & ~gc_hit;
                        if ((stage_reg == `ISAT_STAGE_FIRST) & m10 & ~gc_hit & ~rw)
                           stage_reg <= `ISAT_STAGE_SECOND;
                        else
                           stage_reg <= `ISAT_STAGE_DATA;
                        if (stage_reg == `ISAT_STAGE_SECOND)
                           tenbit_ok_reg <= 1'b1;
                     end
                     else
                        state_reg <= ST_IDLE;
                  end
               end
               ST_ACK:
               begin
                  if (scl_rise)
                     cnt_reg <= `ISAT_ACK_SLOT;
                  else if (scl_fall & (cnt_reg == `ISAT_ACK_SLOT))
                  begin
                     sda_oe <= 1'b0;
                     cnt_reg <= 4'h0;
                     ua_hold_reg <= ua_pend_reg;
                     if (tx_pend_reg)
                     begin
                        tx_hold_reg <= 1'b1;
                        clock_release_bit <= 1'b0;
                        state_reg <= ST_TX;
                     end
                     else
                        state_reg <= ST_RX;
                  end
               end
               ST_TX:
               begin
                  sda_oe <= ~shift_reg[DATA_W-1];
                  if (scl_rise)
                     cnt_reg <= cnt_reg + 4'h1;
                  else if (scl_fall & (cnt_reg != 4'h0))
                  begin
                     if (cnt_reg == `ISAT_BITS_PER_BYTE)
                     begin
                        sda_oe <= 1'b0;
                        state_reg <= ST_TXACK;
                     end
                     else
                        shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
                  end
               end
               ST_TXACK:
               begin
                  sda_oe <= 1'b0;
                  if (scl_rise)
                  begin
                     cnt_reg <= `ISAT_ACK_SLOT;
                     nack_reg <= sda_s2_reg;
                  end
                  else if (scl_fall & (cnt_reg == `ISAT_ACK_SLOT))
                  begin
                     cnt_reg <= 4'h0;
                     if (nack_reg)
                        state_reg <= ST_IDLE;
                     else
                     begin
                        state_reg <= ST_TX;
                        tx_hold_reg <= 1'b1;
                        clock_release_bit <= 1'b0;
                     end
                  end
               end
               default:
               begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Clock stretch: pins only pulled low, both receive slots taken also stalls the bus
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         scl_oe <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
      else
      begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         scl_oe <= active & (tx_hold_reg | ua_hold_reg
                   | (~fifo_in_ready & (state_reg != ST_IDLE) & ~scl_s2_reg));
      end
   end
endmodule

/* isat_slave_asserts.sv */
// Concurrent checks on the two-wire slave ports
`timescale 1ns/1ps
`include "isat_defs.vh"
module isat_slave_asserts (
   input wire clk_sys,
   input wire rst,
   input wire scl_out,
   input wire scl_oe,
   input wire sda_out,
   input wire sda_oe,
   input wire port_enable_bit,
   input wire [3:0] mode_sel,
   input wire own_address_wr,
   input wire clock_release_set,
   input wire buffer_rd,
   input wire buffer_full_flag,
   input wire receive_overflow_flag,
   input wire overflow_clear,
   input wire serial_irq_flag,
   input wire irq_flag_clear,
   input wire irq_enable,
   input wire sleep_mode,
   input wire wake_req,
   input wire address_refresh_flag,
   input wire direction_flag
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Valid slave mode selected
   wire mode_ok = (mode_sel == `ISAT_MODE_SLAVE7) || (mode_sel == `ISAT_MODE_SLAVE10);
   // Pin drive and idle behaviour
   property p_pins_low;
      (scl_oe |-> !scl_out) and (sda_oe |-> !sda_out);
   endproperty
   a_pins_low: assert property (p_pins_low) else $error("pin driven high");
   property p_off;
      !port_enable_bit [*3] |-> !scl_oe && !sda_oe;
   endproperty
   a_off: assert property (p_off) else $error("pins used while disabled");
   property p_bad_mode;
      !mode_ok [*3] |-> !scl_oe && !sda_oe;
   endproperty
   a_bad_mode: assert property (p_bad_mode) else $error("pins used in bad mode");
   property p_reset_clean;
      $past(rst) |-> !scl_oe && !sda_oe && !serial_irq_flag && !buffer_full_flag;
   endproperty
   a_reset_clean: assert property (p_reset_clean) else $error("state after reset");
   // Flags that only software clears
   property p_ovf_keep;
      receive_overflow_flag && !overflow_clear |=> receive_overflow_flag;
   endproperty
   a_ovf_keep: assert property (p_ovf_keep) else $error("overflow dropped");
   property p_irq_keep;
      serial_irq_flag && !irq_flag_clear |=> serial_irq_flag;
   endproperty
   a_irq_keep: assert property (p_irq_keep) else $error("irq flag dropped");
   // Clock hold and its release
   property p_ua_clear;
      own_address_wr |=> !address_refresh_flag;
   endproperty
   a_ua_clear: assert property (p_ua_clear) else $error("refresh flag kept");
   property p_hold_keep;
      scl_oe && port_enable_bit && mode_ok && !clock_release_set && !own_address_wr
         && !buffer_rd && !$past(clock_release_set) && !$past(own_address_wr) |=> scl_oe;
   endproperty
   a_hold_keep: assert property (p_hold_keep) else $error("hold lost");
   property p_release;
      scl_oe && clock_release_set && !address_refresh_flag |=> ##1 !scl_oe;
   endproperty
   a_release: assert property (p_release) else $error("hold not released");
   property p_hold_irq;
      $rose(scl_oe) |-> serial_irq_flag;
   endproperty
   a_hold_irq: assert property (p_hold_irq) else $error("hold without irq");
   // Acknowledge and wake
   property p_no_ack;
      $rose(sda_oe) && !direction_flag |-> !receive_overflow_flag;
   endproperty
   a_no_ack: assert property (p_no_ack) else $error("ack during overflow");
   property p_wake;
      $rose(wake_req) |-> $past(sleep_mode) && $past(irq_enable);
   endproperty
   a_wake: assert property (p_wake) else $error("wake without sleep");
   c_ack: cover property ($rose(sda_oe) && !direction_flag);
   c_hold: cover property ($rose(scl_oe));
   c_ovf: cover property ($rose(receive_overflow_flag));
endmodule
bind isat_slave isat_slave_asserts u_asserts (.*);

/* isat_bus_master.sv */
// Behavioural two-wire bus master that clocks the slave
`timescale 1ns/1ps
module isat_bus_master (
   input wire clk_sys,
   input wire scl_line,
   input wire sda_line,
   output reg scl_pull,
   output reg sda_pull
);
   initial
   begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   // Wait system clocks, moving lines off the sampling edge
   task cyc(input integer n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Free the clock, then wait while the slave stretches it
   task rise_scl;
   begin
      scl_pull = 1'b0;
      wait (scl_line === 1'b1);
      cyc(4);
   end
   endtask
   // Start or repeated start: data falls with clock high
   task start;
   begin
      cyc(2);
      sda_pull = 1'b0;
      cyc(2);
      rise_scl;
      sda_pull = 1'b1;
      cyc(4);
      scl_pull = 1'b1;
   end
   endtask
   // Stop: data rises with clock high
   task stop;
   begin
      cyc(2);
      sda_pull = 1'b1;
      cyc(2);
      rise_scl;
      sda_pull = 1'b0;
      cyc(4);
   end
   endtask
   // Nine pulses MSB first; data set mid-low, sampled late in high
   task xfer9(input [8:0] d, output [8:0] q);
      integer i;
   begin
      for (i = 8; i >= 0; i = i - 1)
      begin
         cyc(2);
         sda_pull = ~d[i];
         cyc(2);
         rise_scl;
         q[i] = sda_line;
         scl_pull = 1'b1;
      end
   end
   endtask
endmodule

/* isat_slave_tb.sv */
// Self-checking bench for the two-wire slave block
`timescale 1ns/1ps
`include "isat_defs.vh"
module isat_slave_tb;
   reg clk_sys, rst, port_enable_bit, general_call_enable, own_address_wr, buffer_rd;
   reg tx_wr, clock_release_set, overflow_clear, irq_flag_clear, irq_enable, sleep_mode;
   reg [3:0] mode_sel;
   reg [7:0] own_address_data, tx_data;
   reg [8:0] q;
   wire scl_out, scl_oe, sda_out, sda_oe, buffer_full_flag, clock_release_bit, wake_req;
   wire receive_overflow_flag, serial_irq_flag, address_refresh_flag, direction_flag;
   wire m_scl, m_sda;
   wire [7:0] serial_data_buffer;
   // Open-drain wires with pull-ups
   wire scl = (scl_oe ? scl_out : 1'b1) & ~m_scl;
   wire sda = (sda_oe ? sda_out : 1'b1) & ~m_sda;
   integer num_errors = 0;
   integer num_checks = 0;
   integer cycles = 0;
   isat_slave u_dut (.*, .scl_in(scl), .sda_in(sda));
   isat_bus_master u_master (.clk_sys(clk_sys), .scl_line(scl), .sda_line(sda),
      .scl_pull(m_scl), .sda_pull(m_sda));
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Hang guard
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors = num_errors + 1;
         complete_run;
      end
   end
   task complete_run;
   begin
      if (num_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   task chk(input [11:0] g, input [11:0] e);
   begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: got %h exp %h", $time, g, e);
      end
   end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge clk_sys);
   endtask
   // One-cycle software strobes
   task sw_own(input [7:0] d);
   begin
      own_address_data = d;
      own_address_wr = 1'b1;
      cyc(1);
      own_address_wr = 1'b0;
   end
   endtask
   task sw_pop;
   begin
      buffer_rd = 1'b1;
      irq_flag_clear = 1'b1;
      cyc(1);
      buffer_rd = 1'b0;
      irq_flag_clear = 1'b0;
   end
   endtask
   task sw_tx(input [7:0] d);
   begin
      tx_data = d;
      tx_wr = 1'b1;
      cyc(1);
      tx_wr = 1'b0;
      clock_release_set = 1'b1;
      cyc(1);
      clock_release_set = 1'b0;
   end
   endtask
   // Write one byte and judge the acknowledge bit
   task send(input [7:0] d, input ack);
   begin
      u_master.xfer9({d, 1'b1}, q);
      cyc(6);
      chk(q[0], ack);
   end
   endtask
   // Seven-bit write with sleep wake and overflow paths
   task t_write7;
   begin
      sleep_mode = 1'b1;
      u_master.start;
      send(8'h5A, 1'b0);
      chk(serial_data_buffer, 8'h5A);
      chk({buffer_full_flag, serial_irq_flag, direction_flag, wake_req}, 4'hD);
      sleep_mode = 1'b0;
      sw_pop;
      send(8'h3C, 1'b0);
      send(8'hC3, 1'b1);
      chk({serial_data_buffer, receive_overflow_flag}, {8'h3C, 1'b1});
      sw_pop;
      cyc(1);
      chk({buffer_full_flag, receive_overflow_flag}, 2'h1);
      send(8'h99, 1'b1);
      chk({serial_data_buffer, serial_irq_flag}, {8'h99, 1'b1});
      overflow_clear = 1'b1;
      cyc(1);
      overflow_clear = 1'b0;
      sw_pop;
      chk(receive_overflow_flag, 1'b0);
      u_master.stop;
   end
   endtask
   // Mismatch, then general call off and on
   task t_gcall;
   begin
      u_master.start;
      send(8'h5C, 1'b1);
      chk(buffer_full_flag, 1'b0);
      u_master.start;
      send(8'h00, 1'b1);
      general_call_enable = 1'b1;
      u_master.start;
      send(8'h00, 1'b0);
      chk({serial_data_buffer, buffer_full_flag, direction_flag}, 10'h2);
      sw_pop;
      u_master.stop;
      general_call_enable = 1'b0;
   end
   endtask
   // Slave transmit with a late release while the master waits
   task t_read;
   begin
      u_master.start;
      send(8'h5B, 1'b0);
      chk({serial_data_buffer, direction_flag, scl_oe}, {8'h5B, 2'h3});
      chk(clock_release_bit, 1'b0);
      sw_pop;
      sw_tx(8'hA5);
      chk(clock_release_bit, 1'b1);
      u_master.xfer9(9'h1FE, q);
      cyc(6);
      chk({q[8:1], serial_irq_flag, scl_oe}, {8'hA5, 2'h3});
      chk(clock_release_bit, 1'b0);
      sw_pop;
      fork
         u_master.xfer9(9'h1FF, q);
         begin
            cyc(20);
            sw_tx(8'h5C);
         end
      join
      cyc(6);
      chk({q[8:1], scl_oe, clock_release_bit}, {8'h5C, 2'h1});
      sw_pop;
      u_master.stop;
   end
   endtask
   // Ten-bit address halves, repeated start read, general call
   task t_ten;
   begin
      mode_sel = `ISAT_MODE_SLAVE10;
      sw_own(8'hF2);
      u_master.start;
      send(8'hF2, 1'b0);
      chk({address_refresh_flag, buffer_full_flag, serial_irq_flag, scl_oe}, 4'hF);
      sw_own(8'h37);
      cyc(1);
      chk({address_refresh_flag, scl_oe}, 2'h0);
      sw_pop;
      send(8'h37, 1'b0);
      chk({address_refresh_flag, scl_oe}, 2'h3);
      sw_own(8'hF2);
      sw_pop;
      send(8'h11, 1'b0);
      chk(serial_data_buffer, 8'h11);
      sw_pop;
      u_master.start;
      send(8'hF3, 1'b0);
      chk({direction_flag, address_refresh_flag, scl_oe}, 3'h5);
      sw_pop;
      sw_tx(8'h81);
      u_master.xfer9(9'h1FF, q);
      chk(q[8:1], 8'h81);
      u_master.stop;
      general_call_enable = 1'b1;
      u_master.start;
      send(8'h00, 1'b0);
      chk({address_refresh_flag, scl_oe}, 2'h0);
      sw_pop;
      send(8'h66, 1'b0);
      chk(serial_data_buffer, 8'h66);
      sw_pop;
      u_master.stop;
      general_call_enable = 1'b0;
      mode_sel = `ISAT_MODE_SLAVE7;
      sw_own(8'h5A);
   end
   endtask
   // Reset during a held read, then disabled and bad mode
   task t_reset;
   begin
      u_master.start;
      send(8'h5B, 1'b0);
      rst = 1'b1;
      cyc(3);
      rst = 1'b0;
      cyc(1);
      chk({scl_oe, sda_oe, buffer_full_flag, serial_irq_flag, direction_flag}, 5'h0);
      u_master.stop;
      sw_own(8'h5A);
      port_enable_bit = 1'b0;
      u_master.start;
      send(8'h5A, 1'b1);
      port_enable_bit = 1'b1;
      mode_sel = 4'h0;
      u_master.start;
      send(8'h5A, 1'b1);
      chk(buffer_full_flag, 1'b0);
      mode_sel = `ISAT_MODE_SLAVE7;
      u_master.stop;
   end
   endtask
   initial
   begin
      rst = 1'b1;
      port_enable_bit = 1'b1;
      mode_sel = `ISAT_MODE_SLAVE7;
      general_call_enable = 1'b0;
      own_address_wr = 1'b0;
      own_address_data = 8'h00;
      buffer_rd = 1'b0;
      tx_wr = 1'b0;
      tx_data = 8'h00;
      clock_release_set = 1'b0;
      overflow_clear = 1'b0;
      irq_flag_clear = 1'b0;
      irq_enable = 1'b1;
      sleep_mode = 1'b0;
      cyc(6);
      rst = 1'b0;
      cyc(4);
      sw_own(8'h5A);
      t_write7;
      t_gcall;
      t_read;
      t_ten;
      t_reset;
      complete_run;
   end
endmodule
